// file: inc/adl_pkg.sv
package adl_pkg;
    localparam int DATA_W = 24;
    localparam int FRAC_SHIFT = 24;
    localparam int RAMADR_W = 8;
    localparam int RAMADR_STEP = 1;
    localparam int LOGIC_REG_CYCLES = 3;
    localparam int LOGIC_IMM_CYCLES = 6;
    localparam int DIV_ITER = 48;
    localparam int DIVMOD_ITER = 24;
    localparam logic [23:0] ACC_RESET = 24'h000000;
    localparam logic [7:0] RAMADR_RESET = 8'h00;

    typedef enum logic [2:0] {
        ADL_OP_NONE = 3'h0,
        ADL_OP_DECRAMADR = 3'h1,
        ADL_OP_FRACDIV = 3'h2,
        ADL_OP_DIVMOD = 3'h3,
        ADL_OP_XOR = 3'h4,
        ADL_OP_XNOR = 3'h5
    } adl_op_e;

    typedef enum logic [1:0] {
        ADL_ST_IDLE = 2'h0,
        ADL_ST_LOGIC = 2'h1,
        ADL_ST_DIV = 2'h2,
        ADL_ST_DONE = 2'h3
    } adl_state_e;
endpackage : adl_pkg

// file: src/adl_datapath.sv
// What this block does
// - RAM pointer decrement lowers the pointer by one in one cycle
// - Fractional divide: first shifted left 24, over second, into first
// - Fractional divide is signed and sets sign and zero from the first
// - Divmod: quotient to first, remainder to second, sign and zero updated
// - Divmod is signed; the 24-bit quotient lands in the first operand
// - XOR writes bitwise difference into the first and sets sign and zero
// - Logic second operand is a register (3 cycles) or immediate (6 cycles)
// - XNOR writes bitwise equality into the first and sets sign and zero
`timescale 1ns/1ps
`default_nettype none
module adl_datapath #(
    parameter int DW = adl_pkg::DATA_W,
    parameter int AW = adl_pkg::RAMADR_W
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic opValid,
    input wire adl_pkg::adl_op_e opCode,
    input wire logic [1:0] srcA,
    input wire logic [1:0] srcB,
    input wire logic useImm,
    input wire logic [DW-1:0] immData,
    output logic busy,
    output logic done,
    output logic [DW-1:0] accX,
    output logic [DW-1:0] accY,
    output logic [DW-1:0] accZ,
    output logic [DW-1:0] accR,
    output logic [AW-1:0] ramAdr,
    output logic flagS,
    output logic flagZ
);
    localparam int PW = 2 * DW;
    localparam logic [6:0] FRAC_ITER = 7'(adl_pkg::DIV_ITER);
    localparam logic [6:0] DM_ITER = 7'(adl_pkg::DIVMOD_ITER);
    localparam logic [2:0] REG_WAIT = 3'(adl_pkg::LOGIC_REG_CYCLES - 2);
    localparam logic [2:0] IMM_WAIT = 3'(adl_pkg::LOGIC_IMM_CYCLES - 2);

    adl_pkg::adl_state_e state_reg;
    adl_pkg::adl_op_e op_reg;
    logic [DW-1:0] acc_reg [4];
    logic [1:0] dstA_reg, dstB_reg;
    logic [2:0] wait_reg;
    logic [6:0] iter_reg;
    logic [PW-1:0] num_reg;
    logic [DW-1:0] den_reg;
    logic [PW-1:0] quo_reg;
    logic [PW:0] rem_reg;
    logic negQ_reg, negR_reg;
    logic [DW-1:0] opB_reg, res_reg;
    logic [PW:0] remShift;
    logic [DW-1:0] quoSigned, remSigned;

    function automatic logic [PW-1:0] absWide(input logic [PW-1:0] v);
        return v[PW-1] ? PW'(-v) : v;
    endfunction : absWide

    function automatic logic [DW-1:0] absNarrow(input logic [DW-1:0] v);
        return v[DW-1] ? DW'(-v) : v;
    endfunction : absNarrow

    assign remShift = {rem_reg[PW-1:0], num_reg[PW-1]};
    // Final quotient keeps the low 24 bits; remainder takes dividend sign
    assign quoSigned = negQ_reg ? DW'(-quo_reg[DW-1:0]) : quo_reg[DW-1:0];
    assign remSigned = negR_reg ? DW'(-rem_reg[DW-1:0]) : rem_reg[DW-1:0];

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= adl_pkg::ADL_ST_IDLE;
            op_reg <= adl_pkg::ADL_OP_NONE;
            dstA_reg <= 2'h0;
            dstB_reg <= 2'h0;
            wait_reg <= 3'h0;
            iter_reg <= 7'h00;
            num_reg <= '0;
            den_reg <= '0;
            quo_reg <= '0;
            rem_reg <= '0;
            negQ_reg <= 1'b0;
            negR_reg <= 1'b0;
            opB_reg <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state_reg)
                adl_pkg::ADL_ST_IDLE: begin
                    if (opValid) begin
                        op_reg <= opCode;
                        dstA_reg <= srcA;
                        dstB_reg <= srcB;
                        case (opCode)
                            adl_pkg::ADL_OP_DECRAMADR: begin
                                done <= 1'b1;
                            end
                            adl_pkg::ADL_OP_XOR, adl_pkg::ADL_OP_XNOR: begin
                                opB_reg <= useImm ? immData : acc_reg[srcB];
                                wait_reg <= useImm ? IMM_WAIT :
                                    REG_WAIT;
                                busy <= 1'b1;
                                state_reg <= adl_pkg::ADL_ST_LOGIC;
                            end
                            adl_pkg::ADL_OP_FRACDIV: begin
                                // Sign-extended first operand shifted by 24
                                num_reg <= absWide(PW'({
                                    {DW{acc_reg[srcA][DW-1]}},
                                    acc_reg[srcA]}) << adl_pkg::FRAC_SHIFT);
                                den_reg <= absNarrow(acc_reg[srcB]);
                                negQ_reg <= acc_reg[srcA][DW-1] ^
                                    acc_reg[srcB][DW-1];
                                negR_reg <= acc_reg[srcA][DW-1];
                                quo_reg <= '0;
                                rem_reg <= '0;
                                iter_reg <= FRAC_ITER;
                                busy <= 1'b1;
                                state_reg <= adl_pkg::ADL_ST_DIV;
                            end
                            adl_pkg::ADL_OP_DIVMOD: begin
                                num_reg <= {absNarrow(acc_reg[srcA]),
                                    {DW{1'b0}}};
                                den_reg <= absNarrow(acc_reg[srcB]);
                                negQ_reg <= acc_reg[srcA][DW-1] ^
                                    acc_reg[srcB][DW-1];
                                negR_reg <= acc_reg[srcA][DW-1];
                                quo_reg <= '0;
                                rem_reg <= '0;
                                iter_reg <= DM_ITER;
                                busy <= 1'b1;
                                state_reg <= adl_pkg::ADL_ST_DIV;
                            end
                            default: begin
                                done <= 1'b1;
                            end
                        endcase
                    end
                end
                adl_pkg::ADL_ST_LOGIC: begin
                    if (wait_reg == 3'h1) begin
                        state_reg <= adl_pkg::ADL_ST_DONE;
                    end
                    wait_reg <= wait_reg - 3'h1;
                end
                adl_pkg::ADL_ST_DIV: begin
                    // Restoring division, one quotient bit a cycle
                    num_reg <= {num_reg[PW-2:0], 1'b0};
                    if (remShift >= {{(DW+1){1'b0}}, den_reg}) begin
                        rem_reg <= remShift - {{(DW+1){1'b0}}, den_reg};
                        quo_reg <= {quo_reg[PW-2:0], 1'b1};
                    end else begin
                        rem_reg <= remShift;
                        quo_reg <= {quo_reg[PW-2:0], 1'b0};
                    end
                    iter_reg <= iter_reg - 7'h01;
                    if (iter_reg == 7'h01) begin
                        state_reg <= adl_pkg::ADL_ST_DONE;
                    end
                end
                adl_pkg::ADL_ST_DONE: begin
                    busy <= 1'b0;
                    done <= 1'b1;
                    state_reg <= adl_pkg::ADL_ST_IDLE;
                end
                default: begin
                    state_reg <= adl_pkg::ADL_ST_IDLE;
                end
            endcase
        end
    end

    // Logic result is computed once the operand is latched
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            res_reg <= '0;
        end else if (state_reg == adl_pkg::ADL_ST_LOGIC) begin
            if (op_reg == adl_pkg::ADL_OP_XOR) begin
                res_reg <= acc_reg[dstA_reg] ^ opB_reg;
            end else begin
                res_reg <= ~(acc_reg[dstA_reg] ^ opB_reg);
            end
        end
    end

    // Write-back; divmod writes the remainder after the quotient so that
    // equal operand indices leave the remainder
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < 4; i++) begin
                acc_reg[i] <= adl_pkg::ACC_RESET;
            end
            flagS <= 1'b0;
            flagZ <= 1'b0;
        end else if (state_reg == adl_pkg::ADL_ST_DONE) begin
            case (op_reg)
                adl_pkg::ADL_OP_XOR, adl_pkg::ADL_OP_XNOR: begin
                    acc_reg[dstA_reg] <= res_reg;
                    flagS <= res_reg[DW-1];
                    flagZ <= (res_reg == '0);
                end
                adl_pkg::ADL_OP_FRACDIV: begin
                    // Out-of-range input gives an undefined quotient
                    acc_reg[dstA_reg] <= quoSigned;
                    flagS <= quoSigned[DW-1];
                    flagZ <= (quoSigned == '0);
                end
                adl_pkg::ADL_OP_DIVMOD: begin
                    acc_reg[dstA_reg] <= quoSigned;
                    acc_reg[dstB_reg] <= remSigned;
                    flagS <= quoSigned[DW-1];
                    flagZ <= (quoSigned == '0);
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ramAdr <= AW'(adl_pkg::RAMADR_RESET);
        end else if (state_reg == adl_pkg::ADL_ST_IDLE && opValid &&
                     opCode == adl_pkg::ADL_OP_DECRAMADR) begin
            ramAdr <= ramAdr - AW'(adl_pkg::RAMADR_STEP);
        end
    end

    assign accX = acc_reg[0];
    assign accY = acc_reg[1];
    assign accZ = acc_reg[2];
    assign accR = acc_reg[3];
    property p_decr;
        @(posedge clk) disable iff (!resetn)
        (state_reg == adl_pkg::ADL_ST_IDLE && opValid &&
         opCode == adl_pkg::ADL_OP_DECRAMADR)
        |=> (ramAdr == AW'($past(ramAdr) - 1)) && done;
    endproperty
    a_decr: assert property (p_decr) else $error("decr wrong");
    property p_logic_reg;
        @(posedge clk) disable iff (!resetn)
        (state_reg == adl_pkg::ADL_ST_IDLE && opValid && !useImm &&
         (opCode == adl_pkg::ADL_OP_XOR || opCode == adl_pkg::ADL_OP_XNOR))
        |=> busy [*2] ##1 done;
    endproperty
    a_logic_reg: assert property (p_logic_reg) else $error("late");
    property p_logic_imm;
        @(posedge clk) disable iff (!resetn)
        (state_reg == adl_pkg::ADL_ST_IDLE && opValid && useImm &&
         (opCode == adl_pkg::ADL_OP_XOR || opCode == adl_pkg::ADL_OP_XNOR))
        |=> busy [*5] ##1 done;
    endproperty
    a_logic_imm: assert property (p_logic_imm) else $error("late");
    property p_xor;
        @(posedge clk) disable iff (!resetn)
        (state_reg == adl_pkg::ADL_ST_DONE && op_reg == adl_pkg::ADL_OP_XOR)
        |=> acc_reg[$past(dstA_reg)] ==
            ($past(acc_reg[dstA_reg]) ^ $past(opB_reg));
    endproperty
    a_xor: assert property (p_xor) else $error("xor result wrong");
    property p_xnor;
        @(posedge clk) disable iff (!resetn)
        (state_reg == adl_pkg::ADL_ST_DONE && op_reg == adl_pkg::ADL_OP_XNOR)
        |=> acc_reg[$past(dstA_reg)] ==
            ~($past(acc_reg[dstA_reg]) ^ $past(opB_reg));
    endproperty
    a_xnor: assert property (p_xnor) else $error("xnor result wrong");
    property p_flags;
        @(posedge clk) disable iff (!resetn)
        done && $past(state_reg) == adl_pkg::ADL_ST_DONE &&
        !(op_reg == adl_pkg::ADL_OP_DIVMOD && dstA_reg == dstB_reg)
        |-> flagS == acc_reg[dstA_reg][DW-1] &&
            flagZ == (acc_reg[dstA_reg] == '0);
    endproperty
    a_flags: assert property (p_flags) else $error("flags");
    property p_div_hold;
        @(posedge clk) disable iff (!resetn)
        (state_reg == adl_pkg::ADL_ST_IDLE && opValid &&
         opCode == adl_pkg::ADL_OP_DIVMOD)
        |=> busy throughout (##[24:24] (state_reg == adl_pkg::ADL_ST_DONE));
    endproperty
    a_div_hold: assert property (p_div_hold) else $error("busy");
    property p_frac_hold;
        @(posedge clk) disable iff (!resetn)
        (state_reg == adl_pkg::ADL_ST_IDLE && opValid &&
         opCode == adl_pkg::ADL_OP_FRACDIV)
        |=> busy throughout (##[48:48] (state_reg == adl_pkg::ADL_ST_DONE));
    endproperty
    a_frac_hold: assert property (p_frac_hold) else $error("busy");
    property p_divmod_res;
        @(posedge clk) disable iff (!resetn)
        (state_reg == adl_pkg::ADL_ST_DONE &&
         op_reg == adl_pkg::ADL_OP_DIVMOD && dstA_reg != dstB_reg)
        |=> acc_reg[$past(dstA_reg)] == $past(quoSigned) &&
            flagZ == ($past(quoSigned) == '0);
    endproperty
    a_divmod_res: assert property (p_divmod_res) else $error("quot");
endmodule : adl_datapath
`default_nettype wire

// file: tb/adl_issuer.sv
`timescale 1ns/1ps
`default_nettype none
module adl_issuer (
    input wire logic clk,
    input wire logic done,
    output logic opValid,
    output adl_pkg::adl_op_e opCode,
    output logic [1:0] srcA,
    output logic [1:0] srcB,
    output logic useImm,
    output logic [23:0] immData
);
    initial begin
        opValid = 1'b0;
        opCode = adl_pkg::ADL_OP_NONE;
        srcA = 2'h0;
        srcB = 2'h0;
        useImm = 1'b0;
        immData = 24'h000000;
    end

    // Idle fields carry the inverse of the last request, so a design that
    // reads them without opValid produces a visible difference
    task automatic idle_bus(input logic [1:0] a, input logic [1:0] b,
        input logic imm, input logic [23:0] d);
        opValid <= 1'b0;
        opCode <= adl_pkg::ADL_OP_NONE;
        srcA <= ~a;
        srcB <= ~b;
        useImm <= ~imm;
        immData <= ~d;
    endtask : idle_bus

    // Poke keeps opValid up one more edge with a pointer decrement
    task automatic issue(input adl_pkg::adl_op_e op, input logic [1:0] a,
        input logic [1:0] b, input logic imm, input logic [23:0] d,
        input int reps, input logic poke, output int cyc);
        cyc = 0;
        for (int i = 0; i < reps; i++) begin
            @(posedge clk);
            opValid <= 1'b1;
            opCode <= op;
            srcA <= a;
            srcB <= b;
            useImm <= imm;
            immData <= d;
        end
        @(posedge clk);
        if (poke) begin
            opCode <= adl_pkg::ADL_OP_DECRAMADR;
        end else begin
            idle_bus(a, b, imm, d);
        end
        // Count from the taking edge, looking just after each edge
        #1;
        cyc = 1;
        while (done !== 1'b1 && cyc < 200) begin
            @(posedge clk);
            if (poke && cyc == 1) begin
                idle_bus(a, b, imm, d);
            end
            #1;
            cyc++;
        end
    endtask : issue
endmodule : adl_issuer
`default_nettype wire

// file: tb/tb_working_register_set_divide_logic_ops.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin \
    err_count++; $display("CHECK FAILED %s exp=%0h got=%0h", nm, exp, got); \
    end end
module tb_working_register_set_divide_logic_ops;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic opValid, useImm, busy, done, flagS, flagZ;
    adl_pkg::adl_op_e opCode;
    logic [1:0] srcA, srcB;
    logic [23:0] immData, accX, accY, accZ, accR;
    logic [7:0] ramAdr;
    logic [23:0] acc [4] = '{24'h0, 24'h0, 24'h0, 24'h0};
    logic [7:0] ramM = 8'h00;
    logic fS = 1'b0;
    logic fZ = 1'b0;
    int err_count = 0;
    int num_checks = 0;

    adl_datapath i_dut (.clk(clk), .resetn(resetn), .opValid(opValid),
        .opCode(opCode), .srcA(srcA), .srcB(srcB), .useImm(useImm),
        .immData(immData), .busy(busy), .done(done), .accX(accX),
        .accY(accY), .accZ(accZ), .accR(accR), .ramAdr(ramAdr),
        .flagS(flagS), .flagZ(flagZ));
    adl_issuer i_issuer (.clk(clk), .done(done), .opValid(opValid),
        .opCode(opCode), .srcA(srcA), .srcB(srcB), .useImm(useImm),
        .immData(immData));

    initial begin
        forever #4 clk = ~clk;
    end

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // Model the operation, issue it, then compare every visible result
    task automatic run(input adl_pkg::adl_op_e op, input logic [1:0] a,
        input logic [1:0] b, input logic imm, input logic [23:0] d,
        input int reps, input logic poke);
        logic [23:0] pb, res;
        longint sa, sb, q, rm;
        int cyc, expCyc;
        pb = imm ? d : acc[b];
        sa = $signed(acc[a]);
        sb = $signed(pb);
        res = acc[a];
        expCyc = 1;
        case (op)
            adl_pkg::ADL_OP_DECRAMADR: ramM = ramM - 8'(reps);
            adl_pkg::ADL_OP_XOR: res = acc[a] ^ pb;
            adl_pkg::ADL_OP_XNOR: res = ~(acc[a] ^ pb);
            adl_pkg::ADL_OP_FRACDIV: begin
                q = (sa <<< 24) / sb;
                res = q[23:0];
                expCyc = 50;
            end
            adl_pkg::ADL_OP_DIVMOD: begin
                q = sa / sb;
                rm = sa % sb;
                acc[b] = rm[23:0];
                res = q[23:0];
                expCyc = 26;
            end
            default: begin
            end
        endcase
        if (op == adl_pkg::ADL_OP_XOR || op == adl_pkg::ADL_OP_XNOR) begin
            expCyc = imm ? 6 : 3;
        end
        if (op != adl_pkg::ADL_OP_DECRAMADR &&
            op != adl_pkg::ADL_OP_NONE) begin
            acc[a] = res;
            fS = res[23];
            fZ = (res == 24'h000000);
        end
        i_issuer.issue(op, a, b, imm, d, reps, poke, cyc);
        `CHK("cycles", expCyc, cyc)
        `CHK("busy", 1'b0, busy)
        `CHK("accX", acc[0], accX)
        `CHK("accY", acc[1], accY)
        `CHK("accZ", acc[2], accZ)
        `CHK("accR", acc[3], accR)
        `CHK("ramAdr", ramM, ramAdr)
        `CHK("flagS", fS, flagS)
        `CHK("flagZ", fZ, flagZ)
    endtask : run

    task automatic setreg(input logic [1:0] i, input logic [23:0] v);
        run(adl_pkg::ADL_OP_XOR, i, 2'h0, 1'b1, acc[i] ^ v, 1, 1'b0);
    endtask : setreg

    task automatic test_logic();
        run(adl_pkg::ADL_OP_XOR, 2'h0, 2'h0, 1'b1, 24'h800001, 1, 1'b0);
        run(adl_pkg::ADL_OP_XOR, 2'h1, 2'h0, 1'b1, 24'h000003, 1, 1'b0);
        run(adl_pkg::ADL_OP_XNOR, 2'h2, 2'h0, 1'b1, 24'hffffff, 1, 1'b0);
        run(adl_pkg::ADL_OP_XNOR, 2'h3, 2'h0, 1'b1, 24'h00ff00, 1, 1'b0);
        run(adl_pkg::ADL_OP_XOR, 2'h0, 2'h1, 1'b0, 24'h000000, 1, 1'b0);
        run(adl_pkg::ADL_OP_XNOR, 2'h1, 2'h3, 1'b0, 24'h000000, 1, 1'b0);
    endtask : test_logic

    // A request held up while busy must not move the pointer
    task automatic test_refuse();
        run(adl_pkg::ADL_OP_XOR, 2'h2, 2'h0, 1'b0, 24'h000000, 1, 1'b1);
        run(adl_pkg::ADL_OP_XNOR, 2'h2, 2'h2, 1'b0, 24'h000000, 1, 1'b1);
    endtask : test_refuse

    task automatic test_decr();
        run(adl_pkg::ADL_OP_DECRAMADR, 2'h0, 2'h0, 1'b0, 24'h0, 1, 1'b0);
        run(adl_pkg::ADL_OP_DECRAMADR, 2'h3, 2'h1, 1'b1, 24'h0, 3, 1'b0);
        // No-operation code (ADL_OP_NONE): a done pulse and nothing else
        run(adl_pkg::ADL_OP_NONE, 2'h1, 2'h2, 1'b0, 24'h0, 1, 1'b0);
    endtask : test_decr

    task automatic test_divmod();
        setreg(2'h0, 24'hfffff9);
        setreg(2'h1, 24'h000002);
        run(adl_pkg::ADL_OP_DIVMOD, 2'h0, 2'h1, 1'b0, 24'h0, 1, 1'b0);
        setreg(2'h2, 24'h000002);
        setreg(2'h3, 24'h000005);
        run(adl_pkg::ADL_OP_DIVMOD, 2'h2, 2'h3, 1'b0, 24'h0, 1, 1'b0);
        setreg(2'h3, 24'h000064);
        setreg(2'h0, 24'hfffff9);
        run(adl_pkg::ADL_OP_DIVMOD, 2'h3, 2'h0, 1'b0, 24'h0, 1, 1'b0);
    endtask : test_divmod

    task automatic test_frac();
        setreg(2'h0, 24'h000001);
        setreg(2'h1, 24'h000004);
        run(adl_pkg::ADL_OP_FRACDIV, 2'h0, 2'h1, 1'b0, 24'h0, 1, 1'b0);
        setreg(2'h0, 24'hffffff);
        run(adl_pkg::ADL_OP_FRACDIV, 2'h0, 2'h1, 1'b0, 24'h0, 1, 1'b0);
        setreg(2'h2, 24'h000001);
        setreg(2'h3, 24'h000003);
        run(adl_pkg::ADL_OP_FRACDIV, 2'h2, 2'h3, 1'b0, 24'h0, 1, 1'b0);
        setreg(2'h2, 24'h000000);
        run(adl_pkg::ADL_OP_FRACDIV, 2'h2, 2'h3, 1'b0, 24'h0, 1, 1'b0);
    endtask : test_frac

    // Whole run needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        tally_and_finish();
    end

    initial begin
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        test_logic();
        test_refuse();
        test_decr();
        test_divmod();
        test_frac();
        tally_and_finish();
    end
endmodule : tb_working_register_set_divide_logic_ops
`default_nettype wire
